// ---- core/sbcspi_core.sv ----
// Behaviour
// - Pull-up off in low power when disabled
// - Over-current flags, transmitter keeps running
// - Masked bus fault drives interrupt low
// - Over-temperature stops transmitter, auto recovery
// - Status read with transmit high re-enables
// - Receive short stops transmitter until transition
// - Status read without short clears flag
// - Transmit low one second stops transmitter
// - Status read with transmit high clears
// - Receive-only bit disables transmitter
// - Bus error sets receive-only automatically
// - Receive-only blocks wake, receive follows bus in stop mode
// - Stop mode bus wake raises interrupt
// - Sleep mode bus wake causes reset
// - Byte frame: address, control; summary, status
// - Chip-select fall starts frame, freezes data
// - Drive on rising, sample on falling
// - Exactly eight sampling edges make frame valid
// - Chip-select rise commits; output enable dropped, data forced low
// - Upper nibble carries OR summaries
// - Each address pair returns its status; pair c/d returns zero
// - Over-voltage shuts drivers when enabled
// - Reset sources restore listed register values
// - Power loss flag set at power-on
// - Mode bits select operating mode
`timescale 1ns/10ps
`default_nettype none
module sbcspi_core #(
    parameter int TX_STUCK_CYC = sbcspi_pkg::TX_STUCK_CYC_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     ce,
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_mosi,
    output logic                          spi_miso,
    output logic                          spi_miso_oe,
    input  wire logic                     ext_rst_n,
    input  wire logic                     reset_mode,
    input  wire logic                     txd_pin,
    input  wire logic                     bus_rx,
    input  wire logic                     rxd_pin,
    input  wire logic                     rxd_short,
    input  wire logic                     bus_oc,
    input  wire logic                     bus_ot,
    input  wire logic [2:0]               volt_mon,
    input  wire logic [3:0]               wake_in,
    input  wire logic [3:0]               hs_stat,
    input  wire logic [3:0]               ls_stat,
    input  wire logic [3:0]               wd_stat,
    output logic                          tx_en,
    output logic                          rxd_out,
    output logic                          irq_n,
    output logic                          pullup_on,
    output logic                          wake_thr_sel,
    output logic                          dominant_level_select,
    output logic [1:0]                    slew_sel,
    output sbcspi_pkg::sbcspi_mode_t      mode,
    output logic                          wd_clear,
    output logic                          wake_reset,
    output logic                          drv_shutdown,
    output logic [3:0]                    hs_ctl,
    output logic [3:0]                    ls_ctl,
    output logic [3:0]                    wake_en,
    output logic [3:0]                    tim_ctl,
    output logic [3:0]                    amux_ctl,
    output logic [3:0]                    cfg
);
    import sbcspi_pkg::*;

    function automatic logic pair_hit(input logic [3:0] a, input logic [3:0] base);
        return a[3:1] == base[3:1];
    endfunction

    // Two-flop synchronisers for chip select, external reset and every status pin and level
    localparam int ASY_W = 27;
    logic [ASY_W-1:0] sync1_r;
    logic [ASY_W-1:0] sync2_r;
    logic             cs_n_s;
    logic             ext_rst_s;
    logic             txd_s;
    logic             bus_s;
    logic             rxd_s;
    logic             rs_s;
    logic             oc_s;
    logic             ot_s;
    logic [2:0]       vm_s;
    logic [3:0]       wk_s;
    logic [3:0]       hs_s;
    logic [3:0]       ls_s;
    logic [3:0]       wd_s;

    always_ff @(posedge clk) begin
        sync1_r <= {ext_rst_n, txd_pin, bus_rx, rxd_pin, rxd_short, bus_oc, bus_ot,
                    volt_mon, wake_in, hs_stat, ls_stat, wd_stat, spi_cs_n};
        sync2_r <= sync1_r;
    end
    assign {ext_rst_s, txd_s, bus_s, rxd_s, rs_s, oc_s, ot_s,
            vm_s, wk_s, hs_s, ls_s, wd_s, cs_n_s} = sync2_r;

    // Link side, clocked by the serial clock
    logic       fresh_rx_r;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_sh_r;
    logic [3:0] addr_r;
    logic       rx_tag_r;
    logic [3:0] tx_cnt_r;
    logic       fpar_r;
    logic [3:0] snap_r [8];
    logic [3:0] snap_sum_r;
    logic [3:0] tx_nib;
    logic       tx_bit;

    // Armed while chip select is high so the first edge starts a new frame
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            fresh_rx_r <= 1'b1;
        end else begin
            fresh_rx_r <= 1'b0;
        end
    end

    always_ff @(negedge spi_sclk) begin
        if (fresh_rx_r) begin
            rx_cnt_r <= 4'h1;
            rx_sh_r  <= {7'h00, spi_mosi};
            rx_tag_r <= fpar_r;
        end else begin
            if (rx_cnt_r != CNT_SAT) begin
                rx_cnt_r <= rx_cnt_r + 4'h1;
            end
            rx_sh_r <= {rx_sh_r[6:0], spi_mosi};
        end
        if (!fresh_rx_r && rx_cnt_r == ADDR_LAST - 4'h1) begin
            addr_r <= {rx_sh_r[1:0], spi_mosi, 1'b0};
        end
    end

    assign tx_nib = snap_r[addr_r[3:1]];
    assign tx_bit = (tx_cnt_r < SUM_BITS)   ? snap_sum_r[~tx_cnt_r[1:0]] :
                    (tx_cnt_r < FRAME_BITS) ? tx_nib[~tx_cnt_r[1:0]] : 1'b0;

    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            tx_cnt_r <= 4'h0;
            spi_miso <= 1'b0;
        end else begin
            if (tx_cnt_r != CNT_SAT) begin
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end
            spi_miso <= tx_bit;
        end
    end

    // Core side
    logic         cs_d_r;
    logic         rxd_d_r;
    logic         bus_d_r;
    logic         overvoltage_shutdown_enable_r;
    logic         pullup_en_r;
    sbcspi_mode_t mode_r;
    logic [3:0]   bus_ctl_r;
    logic [3:0]   irq_mask_r;
    logic         rxo_auto_r;
    logic         oc_r;
    logic         ot_r;
    logic         rs_r;
    logic         ts_r;
    logic         ot_dis_r;
    logic         rs_dis_r;
    logic         rs_seen_r;
    logic [26:0]  stk_cnt_r;
    logic [11:0]  dom_cnt_r;
    logic         loss_r;
    logic         isr_wake_r;

    logic       frame_end;
    logic       frame_start;
    logic       frame_ok;
    logic [3:0] f_addr;
    logic [3:0] f_data;
    logic       rst_all;
    logic       rd_vs;
    logic       rd_bus;
    logic       rd_isr;
    logic       ts_dis;
    logic       bus_err;
    logic       receive_only_bit;
    logic       normal;
    logic       stop_m;
    logic       sleep_m;
    logic       lowp;
    logic       bus_rise;
    logic       wake_evt;
    logic [3:0] bus_sr;
    logic [3:0] vs_sr;
    logic [3:0] wus_sr;
    logic [3:0] isr_sr;

    assign frame_end   = cs_n_s & ~cs_d_r;
    assign frame_start = ~cs_n_s & cs_d_r;
    assign f_addr      = rx_sh_r[7:4];
    assign f_data      = rx_sh_r[3:0];
    assign frame_ok    = frame_end & (rx_cnt_r == FRAME_BITS) & (rx_tag_r == fpar_r);
    assign rst_all     = reset_mode | ~ext_rst_s;
    assign rd_vs       = frame_ok & pair_hit(f_addr, A_MODE);
    assign rd_bus      = frame_ok & pair_hit(f_addr, A_BUS);
    assign rd_isr      = frame_ok & pair_hit(f_addr, A_IRQ);

    assign normal  = (mode_r == SBC_NORMAL) | (mode_r == SBC_NRM_WD);
    assign stop_m  = mode_r == SBC_STOP;
    assign sleep_m = mode_r == SBC_SLEEP;
    assign lowp    = stop_m | sleep_m;

    assign ts_dis  = stk_cnt_r == 27'(TX_STUCK_CYC);
    assign bus_err = ot_s | rs_s | ts_dis;
    assign receive_only_bit  = bus_ctl_r[BC_RECEIVE_ONLY_BIT] | rxo_auto_r;
    assign bus_rise = bus_s & ~bus_d_r;
    assign wake_evt = lowp & ~receive_only_bit & bus_rise & (dom_cnt_r == 12'(WAKE_FILT_CYC));

    assign bus_sr = {rs_r, ts_r, ot_r, oc_r};
    assign vs_sr  = {vm_s, loss_r};
    assign wus_sr = wk_s & wake_en;
    assign isr_sr = {2'b00, |bus_sr, isr_wake_r};

    // Edge history and frame parity
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cs_d_r  <= 1'b1;
            rxd_d_r <= 1'b1;
            bus_d_r <= 1'b1;
            fpar_r  <= 1'b0;
        end else if (ce) begin
            cs_d_r  <= cs_n_s;
            rxd_d_r <= rxd_s;
            bus_d_r <= bus_s;
            fpar_r  <= fpar_r ^ frame_start;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            snap_sum_r <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                snap_r[i] <= 4'h0;
            end
        end else if (ce && cs_n_s) begin
            snap_sum_r <= {|vs_sr, |bus_sr, |hs_s, |ls_s};
            snap_r[0]  <= vs_sr;
            snap_r[1]  <= wus_sr;
            snap_r[2]  <= bus_sr;
            snap_r[3]  <= hs_s;
            snap_r[4]  <= ls_s;
            snap_r[5]  <= wd_s;
            snap_r[6]  <= 4'h0;
            snap_r[7]  <= isr_sr;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            {overvoltage_shutdown_enable_r, pullup_en_r} <= MC_FLAG_RST;
        end else if (ce && frame_ok && f_addr == A_MODE) begin
            overvoltage_shutdown_enable_r      <= f_data[MC_OVERVOLTAGE_SHUTDOWN_ENABLE];
            pullup_en_r <= f_data[MC_PULLUP];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || rst_all) begin
            mode_r     <= SBC_NORMAL;
            wake_en    <= WAKE_CTL_RST;
            bus_ctl_r  <= CTL_RST;
            hs_ctl     <= CTL_RST;
            ls_ctl     <= CTL_RST;
            tim_ctl    <= CTL_RST;
            amux_ctl   <= CTL_RST;
            cfg        <= CTL_RST;
            irq_mask_r <= CTL_RST;
        end else if (ce && frame_ok) begin
            unique case (f_addr)
                A_MODE:  mode_r     <= sbcspi_mode_t'(f_data[1:0]);
                A_WAKE:  wake_en    <= f_data;
                A_BUS:   bus_ctl_r  <= f_data;
                A_HS:    hs_ctl     <= f_data;
                A_LS:    ls_ctl     <= f_data;
                A_TIM:   tim_ctl    <= f_data;
                A_AMUX:  amux_ctl   <= f_data;
                A_CFG:   cfg        <= f_data;
                A_IRQ:   irq_mask_r <= f_data;
                default: ;
            endcase
        end
    end

    // Bus fault flags; a new fault wins over a clearing read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            oc_r       <= 1'b0;
            ot_r       <= 1'b0;
            rs_r       <= 1'b0;
            ts_r       <= 1'b0;
            ot_dis_r   <= 1'b0;
            rs_dis_r   <= 1'b0;
            rs_seen_r  <= 1'b0;
            rxo_auto_r <= 1'b0;
            stk_cnt_r  <= 27'h0;
        end else if (ce) begin
            oc_r <= oc_s | (oc_r & ~(rd_bus & ~oc_s));
            ot_r <= ot_s | (ot_r & ~(rd_bus & ~ot_s));
            ot_dis_r <= ot_s | (ot_dis_r & ~(txd_s & (~ot_s | rd_bus)));
            rs_r <= rs_s | (rs_r & ~(rd_bus & ~rs_s));
            rs_dis_r  <= rs_s | (rs_dis_r & ~(rs_seen_r & txd_s));
            rs_seen_r <= rs_dis_r & ~rs_s & (rs_seen_r | (rxd_s ^ rxd_d_r));
            ts_r <= ts_dis | (ts_r & ~(rd_bus & txd_s));
            stk_cnt_r <= txd_s ? 27'h0 : (ts_dis ? stk_cnt_r : stk_cnt_r + 27'h1);
            rxo_auto_r <= bus_err | (rxo_auto_r & (ot_dis_r | rs_dis_r));
        end
    end

    // Power loss flag and wake recording survive reset mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loss_r     <= 1'b1;
            isr_wake_r <= 1'b0;
            dom_cnt_r  <= 12'h0;
        end else if (ce) begin
            if (rd_vs) begin
                loss_r <= 1'b0;
            end
            isr_wake_r <= wake_evt | (isr_wake_r & ~rd_isr);
            if (bus_s) begin
                dom_cnt_r <= 12'h0;
            end else if (dom_cnt_r != 12'(WAKE_FILT_CYC)) begin
                dom_cnt_r <= dom_cnt_r + 12'h1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_en                 <= 1'b0;
            rxd_out               <= 1'b1;
            irq_n                 <= 1'b1;
            pullup_on             <= 1'b1;
            wake_thr_sel          <= 1'b1;
            dominant_level_select <= 1'b0;
            slew_sel              <= 2'b00;
            mode                  <= SBC_NORMAL;
            wd_clear              <= 1'b0;
            wake_reset            <= 1'b0;
            drv_shutdown          <= 1'b0;
            spi_miso_oe           <= 1'b0;
        end else if (ce) begin
            tx_en <= normal & ~receive_only_bit & ~ot_dis_r & ~rs_dis_r & ~ts_dis & ~bus_err;
            rxd_out <= (normal | (stop_m & receive_only_bit)) ? bus_s : 1'b1;
            irq_n <= ~((|bus_sr & irq_mask_r[IM_BUS]) | isr_wake_r);
            pullup_on             <= ~lowp | pullup_en_r;
            wake_thr_sel          <= pullup_en_r;
            dominant_level_select <= bus_ctl_r[BC_DOMINANT_LEVEL_SELECT];
            slew_sel              <= bus_ctl_r[1:0];
            mode                  <= mode_r;
            wd_clear              <= frame_ok & (f_addr == A_MODE) & (f_data[1:0] == SBC_NRM_WD);
            wake_reset            <= wake_evt & sleep_m;
            drv_shutdown          <= overvoltage_shutdown_enable_r & vm_s[2];
            spi_miso_oe           <= ~cs_n_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ovs_shut_a: assert property (ce && overvoltage_shutdown_enable_r && vm_s[2] |=> drv_shutdown)
        else $error("drivers not shut down on over-voltage");
    bus_irq_a: assert property (ce && |bus_sr && irq_mask_r[IM_BUS] |=> !irq_n)
        else $error("masked bus fault did not raise interrupt");
    ot_txoff_a: assert property (ce && ot_s |=> !tx_en && ot_r)
        else $error("transmitter on during over-temperature");
    oc_flag_a: assert property (ce && oc_s |=> oc_r)
        else $error("over-current not flagged");
    stuck_off_a: assert property (ce && ts_dis |=> ts_r && !tx_en)
        else $error("stuck transmit not handled");
    auto_rxo_a: assert property (ce && rs_s |=> rxo_auto_r && rs_dis_r)
        else $error("bus error did not set receive-only");
    receive_only_bit_off_a: assert property (ce && bus_ctl_r[BC_RECEIVE_ONLY_BIT] |=> !tx_en)
        else $error("transmitter on with receive-only");
    bad_frame_a: assert property (ce && frame_end && !frame_ok && !rst_all |=>
        $stable(mode_r) && $stable(bus_ctl_r))
        else $error("invalid frame changed registers");
    loss_clr_a: assert property (ce && rd_vs |=> !loss_r)
        else $error("power loss flag not cleared");
    sleep_wake_a: assert property (ce && wake_evt && sleep_m |=> wake_reset && isr_wake_r)
        else $error("sleep wake not reported");

    frame_c: cover property (frame_ok);
    wake_c: cover property (wake_evt);
    stuck_c: cover property (ts_dis);
endmodule
`default_nettype wire

// ---- core/sbcspi_pkg.sv ----
package sbcspi_pkg;

    // Register addresses (4-bit frame address)
    localparam logic [3:0] A_MODE      = 4'h0;
    localparam logic [3:0] A_VS_ALIAS  = 4'h1;
    localparam logic [3:0] A_WAKE      = 4'h2;
    localparam logic [3:0] A_WAKE_ALS  = 4'h3;
    localparam logic [3:0] A_BUS       = 4'h4;
    localparam logic [3:0] A_BUS_ALIAS = 4'h5;
    localparam logic [3:0] A_HS        = 4'h6;
    localparam logic [3:0] A_HS_ALIAS  = 4'h7;
    localparam logic [3:0] A_LS        = 4'h8;
    localparam logic [3:0] A_LS_ALIAS  = 4'h9;
    localparam logic [3:0] A_TIM       = 4'ha;
    localparam logic [3:0] A_WD_ALIAS  = 4'hb;
    localparam logic [3:0] A_AMUX      = 4'hc;
    localparam logic [3:0] A_CFG       = 4'hd;
    localparam logic [3:0] A_IRQ       = 4'he;
    localparam logic [3:0] A_ISR_ALIAS = 4'hf;

    // Field positions
    localparam int MC_OVERVOLTAGE_SHUTDOWN_ENABLE   = 3;
    localparam int MC_PULLUP = 2;
    localparam int BC_DOMINANT_LEVEL_SELECT   = 3;
    localparam int BC_RECEIVE_ONLY_BIT = 2;
    localparam int IM_BUS    = 1;
    localparam int IS_BUS    = 1;
    localparam int IS_WAKE   = 0;

    // Reset values
    localparam logic [1:0] MC_FLAG_RST  = 2'h3;
    localparam logic [3:0] WAKE_CTL_RST = 4'hf;
    localparam logic [3:0] CTL_RST      = 4'h0;

    // Frame format
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [3:0] ADDR_LAST  = 4'h3;
    localparam logic [3:0] CNT_SAT    = 4'hf;
    localparam logic [3:0] SUM_BITS   = 4'h4;

    // Timing
    localparam int CLK_NS           = 8;
    localparam int TX_STUCK_MS      = 1000;
    localparam int TX_STUCK_CYC_DEF = TX_STUCK_MS * (1000000 / CLK_NS);
    localparam int WAKE_FILT_NS     = 30000;
    localparam int WAKE_FILT_CYC    = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        SBC_NORMAL = 2'b00,
        SBC_STOP   = 2'b01,
        SBC_SLEEP  = 2'b10,
        SBC_NRM_WD = 2'b11
    } sbcspi_mode_t;

endpackage

// ---- verification/sbcspi_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbcspi_host (
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    localparam realtime HALF = 62.5;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b0;
        spi_mosi = 1'b0;
        // A clean rising edge arms the frame logic before the first frame
        #1;
        spi_cs_n = 1'b1;
    end

    task automatic xfer(input logic [7:0] tx, input int edges, output logic [7:0] rx);
        rx = 8'h00;
        spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i < edges; i++) begin
            spi_sclk = 1'b1;
            spi_mosi = tx[7 - (i % 8)];
            #HALF;
            spi_sclk = 1'b0;
            rx = {rx[6:0], spi_miso};
            #HALF;
        end
        spi_cs_n = 1'b1;
        // Released line must not look like held data
        spi_mosi = ~spi_mosi;
        #200;
    endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sbcspi_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

    logic         clk, nrst, ce, ext_rst_n, reset_mode, txd_pin, bus_rx, rxd_pin;
    logic         rxd_short, bus_oc, bus_ot, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic         spi_miso_oe, tx_en, rxd_out, irq_n, pullup_on, wake_thr_sel;
    logic         dominant_level_select, wd_clear, wake_reset, drv_shutdown;
    logic [1:0]   slew_sel;
    logic [2:0]   volt_mon;
    logic [3:0]   wake_in, hs_stat, ls_stat, wd_stat, hs_ctl, ls_ctl, wake_en;
    logic [3:0]   tim_ctl, amux_ctl, cfg;
    logic [7:0]   rx;
    sbcspi_mode_t mode;
    int           n_fail = 0;
    int           samples_checked = 0;
    int           wd_pulses = 0;
    int           wake_pulses = 0;
    logic [19:0]  rows [8] = '{20'h2_3_30_3, 20'h6_a_35_a, 20'h7_0_35_a, 20'h8_5_32_5,
                               20'h9_0_32_5, 20'ha_6_39_6, 20'hc_1_30_1, 20'hd_9_30_9};

    sbcspi_core #(.TX_STUCK_CYC(200)) sbcspi_core_i (
        .clk, .nrst, .ce, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
        .ext_rst_n, .reset_mode, .txd_pin, .bus_rx, .rxd_pin, .rxd_short, .bus_oc,
        .bus_ot, .volt_mon, .wake_in, .hs_stat, .ls_stat, .wd_stat, .tx_en, .rxd_out,
        .irq_n, .pullup_on, .wake_thr_sel, .dominant_level_select, .slew_sel, .mode,
        .wd_clear, .wake_reset, .drv_shutdown, .hs_ctl, .ls_ctl, .wake_en, .tim_ctl,
        .amux_ctl, .cfg
    );

    sbcspi_host sbcspi_host_i (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (wd_clear === 1'b1) begin
            wd_pulses <= wd_pulses + 1;
        end
        if (wake_reset === 1'b1) begin
            wake_pulses <= wake_pulses + 1;
        end
    end

    function automatic logic [3:0] ctl_of(input logic [3:0] a);
        case (a)
            4'h2: return wake_en;
            4'h6, 4'h7: return hs_ctl;
            4'h8, 4'h9: return ls_ctl;
            4'ha: return tim_ctl;
            4'hc: return amux_ctl;
            default: return cfg;
        endcase
    endfunction

    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic frm(input logic [7:0] tx, input logic [7:0] exp);
        sbcspi_host_i.xfer(tx, 8, rx);
        `CHK(rx, exp)
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Run is about 20000 clk; the limit allows more than twice that
    initial begin
        #400000;
        n_fail++;
        final_report();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        ext_rst_n = 1'b1;
        reset_mode = 1'b0;
        txd_pin = 1'b1;
        bus_rx = 1'b1;
        rxd_pin = 1'b1;
        rxd_short = 1'b0;
        bus_oc = 1'b0;
        bus_ot = 1'b0;
        volt_mon = 3'h0;
        wake_in = 4'h0;
        hs_stat = 4'h5;
        ls_stat = 4'h2;
        wd_stat = 4'h9;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        wclk(5);
        `CHK({spi_miso_oe, irq_n, pullup_on, mode, wake_en, hs_ctl}, 13'h0cf0)
        frm(8'h0c, 8'hb1);
        frm(8'h0c, 8'h30);
        `CHK({spi_miso_oe, spi_miso}, 2'b00)
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            frm(rows[i][19:12], rows[i][11:4]);
            `CHK(ctl_of(rows[i][19:16]), rows[i][3:0])
        end
        $display("test register table done");
        for (int m = 3; m >= 0; m--) begin
            frm({6'h03, 2'(m)}, 8'h30);
            `CHK(mode, sbcspi_mode_t'(m))
        end
        `CHK(wd_pulses, 1)
        frm(8'h01, 8'h30);
        `CHK({pullup_on, wake_thr_sel}, 2'b00)
        frm(8'h0c, 8'h30);
        `CHK({pullup_on, wake_thr_sel}, 2'b11)
        $display("test modes done");
        @(posedge clk);
        volt_mon <= 3'b100;
        wclk(8);
        `CHK(drv_shutdown, 1'b1)
        frm(8'h10, 8'hb8);
        @(posedge clk);
        volt_mon <= 3'b000;
        wclk(8);
        `CHK(drv_shutdown, 1'b0)
        $display("test over-voltage done");
        frm(8'he2, 8'h30);
        // Over-current, over-temperature, stuck transmit, receive short in turn
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            bus_oc <= (k == 0);
            bus_ot <= (k == 1);
            txd_pin <= (k != 2);
            rxd_short <= (k == 3);
            wclk(230);
            `CHK({tx_en, irq_n}, {k == 0, 1'b0})
            @(posedge clk);
            bus_oc <= 1'b0;
            bus_ot <= 1'b0;
            txd_pin <= 1'b1;
            rxd_short <= 1'b0;
            // A receive edge ends short recovery; harmless for the other faults
            rxd_pin <= ~rxd_pin;
            wclk(8);
            `CHK(tx_en, 1'b1)
            sbcspi_host_i.xfer(8'h50, (k == 1) ? 9 : 7, rx);
            frm(8'h50, {4'h7, 4'(1 << k)});
            frm(8'h50, 8'h30);
            `CHK(irq_n, 1'b1)
        end
        sbcspi_host_i.xfer(8'h6f, 9, rx);
        `CHK(hs_ctl, 4'ha)
        $display("test bus faults done");
        frm(8'h4f, 8'h30);
        `CHK({tx_en, dominant_level_select, slew_sel}, 4'b0111)
        frm(8'h40, 8'h30);
        `CHK(tx_en, 1'b1)
        $display("test receive only done");
        // Stop wake, sleep wake, then stop with receive-only blocking wake
        for (int m = 1; m <= 3; m++) begin
            frm({5'h08, m == 3, 2'h0}, 8'h30);
            frm({6'h03, 2'(m == 3 ? 1 : m)}, 8'h30);
            @(posedge clk);
            bus_rx <= 1'b0;
            wclk(3800);
            `CHK(rxd_out, m != 3)
            @(posedge clk);
            bus_rx <= 1'b1;
            wclk(8);
            `CHK(irq_n, m == 3)
            frm(8'hf0, {4'h3, 3'h0, m != 3});
            frm(8'hf0, 8'h30);
        end
        `CHK(wake_pulses, 1)
        frm(8'h40, 8'h30);
        frm(8'h0c, 8'h30);
        $display("test bus wake done");
        @(posedge clk);
        ext_rst_n <= 1'b0;
        wclk(6);
        @(posedge clk);
        ext_rst_n <= 1'b1;
        wclk(8);
        `CHK({mode, wake_en, hs_ctl, ls_ctl, cfg}, 18'h0f000)
        frm(8'h10, 8'h30);
        frm(8'h65, 8'h35);
        `CHK(hs_ctl, 4'h5)
        @(posedge clk);
        reset_mode <= 1'b1;
        @(posedge clk);
        reset_mode <= 1'b0;
        wclk(2);
        `CHK(hs_ctl, 4'h0)
        $display("test external reset done");
        final_report();
    end
endmodule
`default_nettype wire
